// File: verilog/alrb_cfg.svh
`ifndef ALRB_CFG_SVH
`define ALRB_CFG_SVH
// Register byte offsets
`define ALRB_OFF_ALARM 8'h00
`define ALRB_OFF_DACRB 8'h04
`define ALRB_OFF_DACSEL 8'h08
`define ALRB_OFF_DACWR 8'h0c
`define ALRB_OFF_IRQST 8'h10
`define ALRB_OFF_IRQMSK 8'h14
`define ALRB_CHCFG_PAGE 4'h2
// Readback word fields
`define ALRB_TYPE_HI 23
`define ALRB_TYPE_LO 22
`define ALRB_ADDR_HI 21
`define ALRB_ADDR_LO 16
`define ALRB_DATA_HI 15
`define ALRB_ALM_TL 21
`define ALRB_ALM_TV 20
`define ALRB_ALM_G_TOP 19
`define ALRB_ALM_C_TOP 11
`define ALRB_ALM_TYPE 2'h3
`define ALRB_ALM_PAD 4'h0
// Channel configuration fields
`define ALRB_CFG_CLR 6
`define ALRB_CFG_TL 6
`define ALRB_CFG_TV 5
`define ALRB_CFG_HI 21
`define ALRB_CFG_LO 7
// Interrupt status bits
`define ALRB_IRQ_TEMP 0
`define ALRB_IRQ_GUARD 1
`define ALRB_IRQ_CLAMP 2
// DAC register reset contents
`define ALRB_GAIN_RST 16'hffff
`define ALRB_OFFS_RST 16'h8000
`define ALRB_X1_RST 16'h0000
`define ALRB_DACS 64
`endif

// File: verilog/alrb_pkg.sv
package alrb_pkg;
   typedef enum logic [1:0]
   {
      RB_NONE = 2'h0,
      RB_GAIN = 2'h1,
      RB_OFFS = 2'h2,
      RB_INPUT = 2'h3
   } alrb_rbtype_t;
endpackage

// File: verilog/alrb_top.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "alrb_cfg.svh"

module alrb_top
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   input wire logic over_temp,
   input wire logic [3:0] guard_fault,
   input wire logic [3:0] clamp_fault,
   output logic temp_alarm_pin_o,
   output logic temp_alarm_pin_oe,
   output logic shared_clamp_guard_alarm_pin_o,
   output logic shared_clamp_guard_alarm_pin_oe,
   output logic irq
);

   // ******************************
   // Decode
   // ******************************
   logic wr_chcfg;
   logic rd_chcfg;
   logic [1:0] bus_ch;
   logic [3:0] clr_ch;
   logic clr_any;
   assign bus_ch = bus_addr[3:2];
   assign wr_chcfg = bus_wr && bus_addr[7:4] == `ALRB_CHCFG_PAGE
                     && bus_addr[1:0] == 2'h0;
   assign rd_chcfg = bus_rd && bus_addr[7:4] == `ALRB_CHCFG_PAGE
                     && bus_addr[1:0] == 2'h0;
   assign clr_any = wr_chcfg && bus_wdata[`ALRB_CFG_CLR];
   assign clr_ch = clr_any ? (4'h1 << bus_ch) : 4'h0;

   // ******************************
   // Live alarm sampling
   // ******************************
   logic temp_alarm_live_ff;
   logic [3:0] guard_fault_live_ff;
   logic [3:0] clamp_live_ff;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         temp_alarm_live_ff <= 1'b0;
         guard_fault_live_ff <= 4'h0;
         clamp_live_ff <= 4'h0;
      end
      else
      begin
         temp_alarm_live_ff <= over_temp;
         guard_fault_live_ff <= guard_fault;
         clamp_live_ff <= clamp_fault;
      end
   end

   // ******************************
   // Latched alarms
   // ******************************
   // Set wins over clear so an event in the clearing cycle stays visible
   logic temp_alarm_latched_ff;
   logic [3:0] guard_fault_latched_ff;
   logic [3:0] clamp_latched_ff;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         temp_alarm_latched_ff <= 1'b0;
      else if (temp_alarm_live_ff)
         temp_alarm_latched_ff <= 1'b1;
      else if (clr_any)
         temp_alarm_latched_ff <= 1'b0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_ch
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
               guard_fault_latched_ff[gi] <= 1'b0;
            else if (guard_fault_live_ff[gi])
               guard_fault_latched_ff[gi] <= 1'b1;
            else if (clr_ch[gi])
               guard_fault_latched_ff[gi] <= 1'b0;
         end
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
               clamp_latched_ff[gi] <= 1'b0;
            else if (clamp_live_ff[gi])
               clamp_latched_ff[gi] <= 1'b1;
            else if (clr_ch[gi])
               clamp_latched_ff[gi] <= 1'b0;
         end
      end
   endgenerate

   // ******************************
   // Alarm pins
   // ******************************
   // Open drain: pulled low while a latched alarm is held
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         temp_alarm_pin_o <= 1'b0;
         temp_alarm_pin_oe <= 1'b0;
         shared_clamp_guard_alarm_pin_o <= 1'b0;
         shared_clamp_guard_alarm_pin_oe <= 1'b0;
      end
      else
      begin
         temp_alarm_pin_oe <= temp_alarm_latched_ff;
         shared_clamp_guard_alarm_pin_oe <= |guard_fault_latched_ff
                                            | |clamp_latched_ff;
      end
   end

   // ******************************
   // Alarm readback word
   // ******************************
   logic [23:0] alarm_word;
   logic [3:0] clamp_fault_latched_n;
   logic [3:0] clamp_fault_live_n;
   assign clamp_fault_latched_n = ~clamp_latched_ff;
   assign clamp_fault_live_n = ~clamp_live_ff;
   assign alarm_word[`ALRB_TYPE_HI:`ALRB_TYPE_LO] = `ALRB_ALM_TYPE;
   assign alarm_word[`ALRB_ALM_TL] = temp_alarm_latched_ff;
   assign alarm_word[`ALRB_ALM_TV] = temp_alarm_live_ff;
   assign alarm_word[3:0] = `ALRB_ALM_PAD;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_word
         assign alarm_word[`ALRB_ALM_G_TOP - 2 * gi] =
            guard_fault_latched_ff[gi];
         assign alarm_word[`ALRB_ALM_G_TOP - 2 * gi - 1] =
            guard_fault_live_ff[gi];
         assign alarm_word[`ALRB_ALM_C_TOP - 2 * gi] =
            clamp_fault_latched_n[gi];
         assign alarm_word[`ALRB_ALM_C_TOP - 2 * gi - 1] =
            clamp_fault_live_n[gi];
      end
   endgenerate

   // ******************************
   // Channel configuration
   // ******************************
   // Clear bit is a command and is never stored
   logic [14:0] chcfg_ff [0:3];
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         for (int i = 0; i < 4; i++)
            chcfg_ff[i] <= 15'h0000;
      else if (wr_chcfg)
         chcfg_ff[bus_ch] <= bus_wdata[`ALRB_CFG_HI:`ALRB_CFG_LO];
   end

   // ******************************
   // DAC registers
   // ******************************
   logic [15:0] gain_mem [0:`ALRB_DACS-1];
   logic [15:0] offs_mem [0:`ALRB_DACS-1];
   logic [15:0] x1_mem [0:`ALRB_DACS-1];
   alrb_pkg::alrb_rbtype_t sel_type_ff;
   logic [5:0] sel_addr_ff;
   logic [1:0] wr_type;
   logic [5:0] wr_addr;
   logic wr_dac;
   assign wr_type = bus_wdata[`ALRB_TYPE_HI:`ALRB_TYPE_LO];
   assign wr_addr = bus_wdata[`ALRB_ADDR_HI:`ALRB_ADDR_LO];
   assign wr_dac = bus_wr && bus_addr == `ALRB_OFF_DACWR;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         for (int i = 0; i < `ALRB_DACS; i++)
         begin
            gain_mem[i] <= `ALRB_GAIN_RST;
            offs_mem[i] <= `ALRB_OFFS_RST;
            x1_mem[i] <= `ALRB_X1_RST;
         end
      else if (wr_dac)
         case (wr_type)
            alrb_pkg::RB_GAIN: gain_mem[wr_addr] <= bus_wdata[15:0];
            alrb_pkg::RB_OFFS: offs_mem[wr_addr] <= bus_wdata[15:0];
            alrb_pkg::RB_INPUT: x1_mem[wr_addr] <= bus_wdata[15:0];
            default: ;
         endcase
   end

   // Type 00 names no register, so such a selection is ignored
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_type_ff <= alrb_pkg::RB_INPUT;
         sel_addr_ff <= 6'h00;
      end
      else if (bus_wr && bus_addr == `ALRB_OFF_DACSEL
               && wr_type != alrb_pkg::RB_NONE)
      begin
         sel_type_ff <= alrb_pkg::alrb_rbtype_t'(wr_type);
         sel_addr_ff <= wr_addr;
      end
   end

   logic [15:0] dac_value_field;
   logic [23:0] dac_word;
   always_comb
   begin
      case (sel_type_ff)
         alrb_pkg::RB_GAIN: dac_value_field = gain_mem[sel_addr_ff];
         alrb_pkg::RB_OFFS: dac_value_field = offs_mem[sel_addr_ff];
         default: dac_value_field = x1_mem[sel_addr_ff];
      endcase
   end
   assign dac_word = {sel_type_ff, sel_addr_ff, dac_value_field};

   // ******************************
   // Interrupts
   // ******************************
   logic [2:0] irq_st_ff;
   logic [2:0] irq_msk_ff;
   logic [2:0] irq_ev;
   logic temp_prev_ff;
   logic [3:0] guard_prev_ff;
   logic [3:0] clamp_prev_ff;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         temp_prev_ff <= 1'b0;
         guard_prev_ff <= 4'h0;
         clamp_prev_ff <= 4'h0;
      end
      else
      begin
         temp_prev_ff <= temp_alarm_live_ff;
         guard_prev_ff <= guard_fault_live_ff;
         clamp_prev_ff <= clamp_live_ff;
      end
   end
   assign irq_ev[`ALRB_IRQ_TEMP] = temp_alarm_live_ff & ~temp_prev_ff;
   assign irq_ev[`ALRB_IRQ_GUARD] = |(guard_fault_live_ff & ~guard_prev_ff);
   assign irq_ev[`ALRB_IRQ_CLAMP] = |(clamp_live_ff & ~clamp_prev_ff);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         irq_st_ff <= 3'h0;
      else if (bus_wr && bus_addr == `ALRB_OFF_IRQST)
         irq_st_ff <= (irq_st_ff & ~bus_wdata[2:0]) | irq_ev;
      else
         irq_st_ff <= irq_st_ff | irq_ev;
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         irq_msk_ff <= 3'h0;
      else if (bus_wr && bus_addr == `ALRB_OFF_IRQMSK)
         irq_msk_ff <= bus_wdata[2:0];
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irq_st_ff & irq_msk_ff);
   end

   // ******************************
   // Read port
   // ******************************
   // Writes to the readback words are ignored; unmapped reads give zero
   logic [31:0] nxt_rdata;
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (rd_chcfg)
      begin
         nxt_rdata[`ALRB_CFG_HI:`ALRB_CFG_LO] = chcfg_ff[bus_ch];
         nxt_rdata[`ALRB_CFG_TL] = temp_alarm_latched_ff;
         nxt_rdata[`ALRB_CFG_TV] = temp_alarm_live_ff;
      end
      else if (bus_rd)
         case (bus_addr)
            `ALRB_OFF_ALARM: nxt_rdata[23:0] = alarm_word;
            `ALRB_OFF_DACRB: nxt_rdata[23:0] = dac_word;
            `ALRB_OFF_DACSEL: nxt_rdata[23:16] = {sel_type_ff, sel_addr_ff};
            `ALRB_OFF_IRQST: nxt_rdata[2:0] = irq_st_ff;
            `ALRB_OFF_IRQMSK: nxt_rdata[2:0] = irq_msk_ff;
            default: nxt_rdata = 32'h0000_0000;
         endcase
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         bus_rdata <= 32'h0000_0000;
      else
         bus_rdata <= nxt_rdata;
   end

   // ******************************
   // Assertions
   // ******************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic rd_alarm;
   logic rd_dac;
   assign rd_alarm = bus_rd && bus_addr == `ALRB_OFF_ALARM;
   assign rd_dac = bus_rd && bus_addr == `ALRB_OFF_DACRB;

   temp_word_a: assert property (rd_alarm |=> bus_rdata[23:20] ==
      {2'h3, $past(temp_alarm_latched_ff), $past(temp_alarm_live_ff)})
      else $error("temperature bits wrong in alarm word");
   temp_latch_a: assert property (over_temp |=> ##1
      temp_alarm_latched_ff ##1 temp_alarm_pin_oe)
      else $error("temperature event not latched");
   clear_latch_a: assert property (clr_any && !temp_alarm_live_ff
      |=> !temp_alarm_latched_ff)
      else $error("clear did not reset latched alarm");
   guard_pair_a: assert property (rd_alarm |=> bus_rdata[19:18] ==
      {$past(guard_fault_latched_ff[0]), $past(guard_fault_live_ff[0])})
      else $error("guard pair misplaced");
   shared_pin_a: assert property (|guard_fault_live_ff
      |=> ##1 shared_clamp_guard_alarm_pin_oe)
      else $error("shared alarm pin not driven");
   clamp_low_a: assert property (rd_alarm && clamp_live_ff[3]
      && clamp_latched_ff[3]
      |=> !bus_rdata[4] && !bus_rdata[5] && bus_rdata[3:0] == 4'h0)
      else $error("clamp bits not active low");
   dac_width_a: assert property (rd_dac |=>
      bus_rdata[31:24] == 8'h00)
      else $error("dac word wider than 24 bits");
   dac_type_a: assert property (rd_dac |=>
      bus_rdata[23:22] == $past(sel_type_ff) && bus_rdata[23:22] != 2'h0)
      else $error("dac readback type wrong");
   dac_addr_a: assert property (rd_dac |=>
      bus_rdata[21:16] == $past(sel_addr_ff))
      else $error("dac readback address wrong");
   dac_data_a: assert property (rd_dac
      && sel_type_ff == alrb_pkg::RB_INPUT
      |=> bus_rdata[15:0] == $past(x1_mem[sel_addr_ff]))
      else $error("dac readback data wrong");
   cfg_mirror_a: assert property (rd_chcfg |=>
      bus_rdata[6] == $past(temp_alarm_latched_ff))
      else $error("temperature mirror missing");
   irq_level_a: assert property (irq == $past(|(irq_st_ff & irq_msk_ff)))
      else $error("interrupt level wrong");

endmodule
`default_nettype wire

// File: sim/alrb_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Host controller model: plain register bus master
// ****************************************************
module alrb_host
(
   input wire logic core_clk,
   output logic [7:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic [31:0] bus_rdata
);
   initial
   begin
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end
   // Strobe drops one edge later, so back-to-back calls leave one idle cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask
   task automatic chan_clear(input logic [1:0] ch);
      wr({4'h2, ch, 2'b00}, 32'h40);
   endtask
endmodule
`default_nettype wire

// File: sim/alarm_and_dac_readback_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "alrb_cfg.svh"
module alarm_and_dac_readback_bench;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic over_temp = 1'b0;
   logic [3:0] guard_fault = 4'h0;
   logic [3:0] clamp_fault = 4'h0;
   logic [7:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic bus_wr;
   logic bus_rd;
   logic tpin_o;
   logic tpin_oe;
   logic spin_o;
   logic spin_oe;
   logic irq;
   int fail_count = 0;
   int cmp_count = 0;
   logic [31:0] rng_state = 32'hbe7d;
   logic m_lt = 1'b0;
   logic [3:0] m_lg = 4'h0;
   logic [3:0] m_lc = 4'h0;
   logic [2:0] m_st = 3'h0;
   logic [2:0] m_mask = 3'h0;
   logic [31:0] r;
   logic [31:0] rdv;

   always #5 core_clk = ~core_clk;

   alrb_top i_dut (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .over_temp(over_temp),
      .guard_fault(guard_fault), .clamp_fault(clamp_fault),
      .temp_alarm_pin_o(tpin_o), .temp_alarm_pin_oe(tpin_oe),
      .shared_clamp_guard_alarm_pin_o(spin_o),
      .shared_clamp_guard_alarm_pin_oe(spin_oe), .irq(irq));
   alrb_host i_host (.core_clk(core_clk), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata));

   // ****************************************************
   // Expectation helpers
   // ****************************************************
   function automatic logic [31:0] xs();
      rng_state ^= rng_state << 13;
      rng_state ^= rng_state >> 17;
      rng_state ^= rng_state << 5;
      return rng_state;
   endfunction
   // Clamp pairs read inverted: a present condition reads as 0
   function automatic logic [31:0] exp_alarm();
      logic [31:0] w;
      w = {8'h00, 2'b11, m_lt, over_temp, 20'h0};
      for (int i = 0; i < 4; i++)
      begin
         w[19 - 2 * i] = m_lg[i];
         w[18 - 2 * i] = guard_fault[i];
         w[11 - 2 * i] = ~m_lc[i];
         w[10 - 2 * i] = ~clamp_fault[i];
      end
      return w;
   endfunction
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic set_alarms(input logic ot, input logic [3:0] g,
      input logic [3:0] c);
      @(posedge core_clk);
      m_st[`ALRB_IRQ_TEMP] |= ot & ~over_temp;
      m_st[`ALRB_IRQ_GUARD] |= |(g & ~guard_fault);
      m_st[`ALRB_IRQ_CLAMP] |= |(c & ~clamp_fault);
      m_lt |= ot;
      m_lg |= g;
      m_lc |= c;
      over_temp <= ot;
      guard_fault <= g;
      clamp_fault <= c;
      repeat (4) @(posedge core_clk);
   endtask
   // Live inputs are held, so a clear leaves a still-present alarm latched
   task automatic clear_chan(input logic [1:0] ch);
      i_host.chan_clear(ch);
      m_lt = over_temp;
      m_lg[ch] = guard_fault[ch];
      m_lc[ch] = clamp_fault[ch];
   endtask
   task automatic check_all();
      logic [1:0] ch;
      logic [31:0] d;
      ch = xs() % 4;
      i_host.rd(`ALRB_OFF_ALARM, d);
      check("alarm word", d, exp_alarm());
      check("temp pin oe", 32'(tpin_oe), 32'(m_lt));
      check("shared pin oe", 32'(spin_oe), 32'(|{m_lg, m_lc}));
      check("pin data", {30'h0, tpin_o, spin_o}, 32'h0);
      i_host.rd({`ALRB_CHCFG_PAGE, ch, 2'b00}, d);
      check("chan cfg", d, {25'h0, m_lt, over_temp, 5'h0});
      i_host.rd(`ALRB_OFF_IRQST, d);
      check("irq status", d, {29'h0, m_st});
      check("irq", 32'(irq), 32'(|(m_st & m_mask)));
   endtask
   task automatic dac_rb(input logic [1:0] ty, input logic [5:0] a,
      input logic [15:0] v);
      logic [31:0] d;
      i_host.wr(`ALRB_OFF_DACSEL, {8'h0, ty, a, 16'h0});
      i_host.rd(`ALRB_OFF_DACRB, d);
      check("dac readback", d, {8'h0, ty, a, v});
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      finish_test();
   end
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      check_all();
      i_host.wr(`ALRB_OFF_ALARM, 32'hffffffff);
      i_host.wr(`ALRB_OFF_DACRB, 32'hffffffff);
      i_host.rd(8'h3c, rdv);
      check("unmapped read", rdv, 32'h0);
      check_all();
      $display("reset and read-only test done");
      dac_rb(2'h1, 6'h3f, `ALRB_GAIN_RST);
      dac_rb(2'h2, 6'h00, `ALRB_OFFS_RST);
      dac_rb(2'h3, 6'h15, `ALRB_X1_RST);
      repeat (8)
      begin
         r = xs();
         r[23:22] = 2'(xs() % 3 + 1);
         i_host.wr(`ALRB_OFF_DACWR, {8'h0, r[23:0]});
         dac_rb(r[23:22], r[21:16], r[15:0]);
         i_host.wr(`ALRB_OFF_DACWR, {8'h0, 2'b00, r[21:16], ~r[15:0]});
         i_host.wr(`ALRB_OFF_DACSEL, 32'h0);
         i_host.rd(`ALRB_OFF_DACRB, rdv);
         check("dac type 0 ignored", rdv, {8'h0, r[23:0]});
      end
      $display("dac test done");
      i_host.wr(`ALRB_OFF_IRQMSK, 32'h5);
      m_mask = 3'h5;
      set_alarms(1'b1, 4'hf, 4'hf);
      clear_chan(2'h0);
      check_all();
      set_alarms(1'b0, 4'h0, 4'h0);
      for (int ch = 0; ch < 4; ch++)
         clear_chan(2'(ch));
      check_all();
      repeat (16)
      begin
         r = xs();
         set_alarms(r[0], r[4:1], r[8:5]);
         check_all();
         if (r[9])
            clear_chan(r[11:10]);
         if (r[12])
            i_host.wr(`ALRB_OFF_IRQMSK, {29'h0, r[15:13]});
         if (r[12])
            m_mask = r[15:13];
         check_all();
         if (r[16])
            i_host.wr(`ALRB_OFF_IRQST, 32'h7);
         if (r[16])
            m_st = 3'h0;
      end
      check_all();
      $display("alarm and interrupt test done");
      finish_test();
   end
endmodule
`default_nettype wire
